// file: core/ufc_pkg.sv
/*
  Constants and types for the UART queue control block: the shared
  control/identification address, control fields, reset values and
  receive thresholds.
  Assumes a byte-wide I/O space and a single system clock.
*/
package ufc_pkg;

  // Shared control / identification address per channel
  localparam logic [7:0] ADDR_CH0 = 8'hC2;
  localparam logic [7:0] ADDR_CH1 = 8'hD2;

  // Control field positions
  localparam int POS_ENABLE = 0;
  localparam int POS_TX_FLUSH = 1;
  localparam int POS_RX_FLUSH = 2;
  localparam int POS_RX_THRESHOLD_SELECT_LO = 6;

  // Value after reset: queues enabled, threshold of one byte
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic ENABLE_RESET = 1'h1;
  localparam logic [1:0] RX_THRESHOLD_SELECT_RESET = 2'h0;

  // Queue capacity when enabled and when acting as a holding byte
  localparam logic [4:0] QUEUE_DEPTH = 5'h10;
  localparam logic [4:0] SINGLE_DEPTH = 5'h01;
  localparam logic [4:0] COUNT_RESET = 5'h00;

  // Receive thresholds per trigger code
  localparam logic [4:0] THR_CODE0 = 5'h01;
  localparam logic [4:0] THR_CODE1 = 5'h04;
  localparam logic [4:0] THR_CODE2 = 5'h08;
  localparam logic [4:0] THR_CODE3 = 5'h0E;

  // Identification read: queue state in bits 7:6
  localparam logic [1:0] STS_ON = 2'h3;
  localparam logic [1:0] STS_OFF = 2'h0;

  typedef struct packed {
    logic [1:0] rx_threshold_select;
    logic [2:0] reserved;
    logic rx_queue_flush;
    logic tx_queue_flush;
    logic queue_enable;
  } ufc_ctrl_t;

endpackage

// file: core/ufc_top.sv
/*
  UART queue control: write-only control register sharing its I/O
  address with the interrupt identification read, plus the transmit and
  receive byte queues it steers and the receive threshold interrupt.
  Assumes the I/O strobes, serial side and identification logic all run
  on clk; pops answer one cycle later.
*/
// Operation
// [R01] Trigger code 00 means one byte, code 01 means four bytes.
// [R02] Trigger code 10 means eight bytes, code 11 means fourteen bytes.
// [R03] Receive data interrupt rises once receive count reaches the threshold.
// [R04] Threshold choice and transmit flush act only while queues are enabled.
// [R05] Writing 1 to bit 1 empties transmit queue; 0 does nothing.
// [R06] Writing 1 to bit 2 empties receive queue; 0 does nothing.
// [R07] Bit 0 enables both queues; clear means one-byte holding buffers.
// [R08] Control is write-only; reads at its address return identification.
// [R09] Shared location is C2h for channel zero, D2h for channel one.
// [R10] Software writes zeros to bits 5:3; the device ignores them.

module ufc_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic flush,
  input wire logic single,
  // Fill side
  input wire logic push,
  input wire logic [7:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [7:0] pop_data_r,
  output logic pop_valid_r,
  output logic [4:0] count_r
);
  logic [7:0] mem [0:15];
  logic [3:0] wr_ptr_r;
  logic [3:0] rd_ptr_r;
  wire [4:0] cap = single ? ufc_pkg::SINGLE_DEPTH : ufc_pkg::QUEUE_DEPTH;
  wire do_push = push && (count_r < cap);
  wire do_pop = pop && (count_r != ufc_pkg::COUNT_RESET);
  wire [4:0] count_nxt = do_push && !do_pop ? count_r + 5'h01 :
                         do_pop && !do_push ? count_r - 5'h01 : count_r;

  always_ff @(posedge clk) begin
    if (do_push && !flush) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      count_r <= ufc_pkg::COUNT_RESET;
      pop_data_r <= 8'h00;
      pop_valid_r <= 1'b0;
    end else if (flush) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      count_r <= ufc_pkg::COUNT_RESET;
      pop_valid_r <= 1'b0;
    end else begin
      wr_ptr_r <= do_push ? wr_ptr_r + 4'h1 : wr_ptr_r;
      rd_ptr_r <= do_pop ? rd_ptr_r + 4'h1 : rd_ptr_r;
      count_r <= count_nxt;
      pop_valid_r <= do_pop;
      if (do_pop) begin
        pop_data_r <= mem[rd_ptr_r];
      end
    end
  end
endmodule

module ufc_top #(
  parameter bit CHANNEL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Processor I/O port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_r,
  // Interrupt identification from the interrupt logic
  input wire logic [2:0] int_code,
  input wire logic int_none,
  // Transmit queue
  input wire logic tx_push,
  input wire logic [7:0] tx_push_data,
  input wire logic tx_pop,
  output logic [7:0] tx_data_r,
  output logic tx_valid_r,
  output logic [4:0] tx_count_r,
  // Receive queue
  input wire logic rx_push,
  input wire logic [7:0] rx_push_data,
  input wire logic rx_pop,
  output logic [7:0] rx_data_r,
  output logic rx_valid_r,
  output logic [4:0] rx_count_r,
  // Receive data interrupt and queue state
  output logic rx_irq_r,
  output logic queue_enable_r
);
  logic [1:0] rx_threshold_select_r;

  // [R09] Channel address select
  wire [7:0] my_addr = CHANNEL ? ufc_pkg::ADDR_CH1 : ufc_pkg::ADDR_CH0;
  wire hit = io_addr == my_addr;
  // [R08] Writes go to control
  wire wr_hit = io_wr && hit;
  wire rd_hit = io_rd && hit;
  // [R10] Bits 5:3 are never looked at
  wire ufc_pkg::ufc_ctrl_t wctl = ufc_pkg::ufc_ctrl_t'(io_wdata);
  // Turning the queues on or off empties both
  wire mode_change = wr_hit && (wctl.queue_enable != queue_enable_r);
  // [R04] [R05] Transmit flush gated by enable
  wire tx_flush = (wr_hit && wctl.tx_queue_flush && wctl.queue_enable) || mode_change;
  // [R06] Receive flush on bit 2
  wire rx_flush = (wr_hit && wctl.rx_queue_flush) || mode_change;

  // [R01] [R02] Threshold decode
  wire [4:0] threshold = rx_threshold_select_r == 2'h0 ? ufc_pkg::THR_CODE0 :
                         rx_threshold_select_r == 2'h1 ? ufc_pkg::THR_CODE1 :
                         rx_threshold_select_r == 2'h2 ? ufc_pkg::THR_CODE2 : ufc_pkg::THR_CODE3;
  // [R03] [R04] Threshold only while enabled
  wire irq_nxt = queue_enable_r ? (rx_count_r >= threshold) : (rx_count_r != ufc_pkg::COUNT_RESET);
  // [R08] Identification read value
  wire [7:0] rdata_nxt = {queue_enable_r ? ufc_pkg::STS_ON : ufc_pkg::STS_OFF, 2'h0, int_code, int_none};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      queue_enable_r <= ufc_pkg::ENABLE_RESET;
      rx_threshold_select_r <= ufc_pkg::RX_THRESHOLD_SELECT_RESET;
      rx_irq_r <= 1'b0;
      io_rdata_r <= 8'h00;
    end else begin
      if (wr_hit) begin
        queue_enable_r <= wctl.queue_enable;
        rx_threshold_select_r <= wctl.rx_threshold_select;
      end
      rx_irq_r <= irq_nxt;
      if (rd_hit) begin
        io_rdata_r <= rdata_nxt;
      end
    end
  end

  // [R07] Holding byte when disabled
  ufc_queue u_tx (
    .clk(clk),
    .reset(reset),
    .flush(tx_flush),
    .single(!queue_enable_r),
    .push(tx_push),
    .push_data(tx_push_data),
    .pop(tx_pop),
    .pop_data_r(tx_data_r),
    .pop_valid_r(tx_valid_r),
    .count_r(tx_count_r)
  );

  ufc_queue u_rx (
    .clk(clk),
    .reset(reset),
    .flush(rx_flush),
    .single(!queue_enable_r),
    .push(rx_push),
    .push_data(rx_push_data),
    .pop(rx_pop),
    .pop_data_r(rx_data_r),
    .pop_valid_r(rx_valid_r),
    .count_r(rx_count_r)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_rx_threshold_select_four: assert property (queue_enable_r && rx_threshold_select_r == 2'h1 && rx_count_r == 5'h04 |=> rx_irq_r) // [R01]
    else $error("irq missing at four bytes");
  chk_rx_threshold_select_below: assert property (queue_enable_r && rx_threshold_select_r == 2'h1 && rx_count_r == 5'h03 |=> !rx_irq_r) // [R01]
    else $error("irq early below four bytes");
  chk_rx_threshold_select_eight: assert property (queue_enable_r && rx_threshold_select_r == 2'h2 && rx_count_r == 5'h07 |=> !rx_irq_r) // [R02]
    else $error("irq early below eight bytes");
  chk_rx_threshold_select_fourteen: assert property (queue_enable_r && rx_threshold_select_r == 2'h3 && rx_count_r == 5'h0E |=> rx_irq_r) // [R02]
    else $error("irq missing at fourteen bytes");
  chk_irq_reach: assert property (queue_enable_r && rx_threshold_select_r == 2'h3 && rx_count_r == 5'h0D |=> !rx_irq_r) // [R03]
    else $error("irq before threshold reached");
  chk_flush_gated: assert property (wr_hit && !queue_enable_r && io_wdata[1] && !io_wdata[0] && !tx_push // [R04]
    && !tx_pop |=> tx_count_r == $past(tx_count_r))
    else $error("tx flush acted while disabled");
  chk_tx_flush: assert property (wr_hit && queue_enable_r && io_wdata[1] && io_wdata[0] |=> tx_count_r == 5'h00) // [R05]
    else $error("tx queue not emptied");
  chk_rx_flush: assert property (wr_hit && io_wdata[2] |=> rx_count_r == 5'h00 ##1 !rx_irq_r) // [R06]
    else $error("rx queue not emptied");
  chk_single_byte: assert property (!queue_enable_r |-> rx_count_r <= 5'h01 && tx_count_r <= 5'h01) // [R07]
    else $error("more than one byte while disabled");
  chk_read_status: assert property (rd_hit |=> io_rdata_r[7:6] == {2{$past(queue_enable_r)}}) // [R08]
    else $error("identification read wrong queue state");
  chk_addr_decode: assert property (io_wr && io_addr != my_addr |=> $stable(queue_enable_r) && $stable(rx_threshold_select_r)) // [R09]
    else $error("foreign address changed control");
  // One-byte threshold, idle flush bits, holding byte and pops
  chk_rx_threshold_select_one: assert property (queue_enable_r && rx_threshold_select_r == 2'h0 && rx_count_r == 5'h01 |=> rx_irq_r) // [R01]
    else $error("irq missing at one byte");
  chk_irq_disabled: assert property (!queue_enable_r && rx_threshold_select_r == 2'h3 && rx_count_r == 5'h01 |=> rx_irq_r) // [R04]
    else $error("threshold applied while disabled");
  chk_tx_keep: assert property (wr_hit && queue_enable_r && io_wdata[0] && !io_wdata[1] && !tx_push // [R05]
    && !tx_pop |=> tx_count_r == $past(tx_count_r))
    else $error("tx queue emptied without flush bit");
  chk_rx_keep: assert property (wr_hit && queue_enable_r && io_wdata[0] && !io_wdata[2] && !rx_push // [R06]
    && !rx_pop |=> rx_count_r == $past(rx_count_r))
    else $error("rx queue emptied without flush bit");
  chk_hold_full: assert property (!queue_enable_r && rx_count_r == 5'h01 && rx_push && !rx_pop // [R07]
    && !rx_flush |=> rx_count_r == 5'h01)
    else $error("holding byte took a second byte");
  chk_tx_pop: assert property (tx_pop && tx_count_r != 5'h00 && !tx_flush |=> tx_valid_r) // [R07]
    else $error("tx pop gave no valid byte");
  chk_rx_pop: assert property (rx_pop && rx_count_r != 5'h00 && !rx_flush |=> rx_valid_r) // [R07]
    else $error("rx pop gave no valid byte");

  cov_rx_fill: cover property (queue_enable_r && rx_threshold_select_r == 2'h3 && rx_count_r == 5'h10);
  cov_disable: cover property (wr_hit && !io_wdata[0] && queue_enable_r);
  cov_tx_flush: cover property (tx_flush && tx_count_r > 5'h01);
  cov_full_drop: cover property (rx_push && rx_count_r == 5'h10);
endmodule

// file: test/tb_uart_fifo_control.sv
/*
  Self-checking bench for the UART queue control block, channel zero.
  Assumes the block answers one cycle after each strobe and that its
  assertions sit inside the design files.
*/
module tb_uart_fifo_control;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, reset, io_wr, io_rd, int_none, tx_push, tx_pop, rx_push, rx_pop;
  logic [7:0] io_addr, io_wdata, tx_push_data, rx_push_data;
  logic [2:0] int_code;
  logic [7:0] io_rdata_r, tx_data_r, rx_data_r;
  logic [4:0] tx_count_r, rx_count_r;
  logic tx_valid_r, rx_valid_r, rx_irq_r, queue_enable_r;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int thr [4] = '{1, 4, 8, 14};

  ufc_top #(.CHANNEL(1'b0)) ufc_top_i (
    .clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_r, .int_code, .int_none,
    .tx_push, .tx_push_data, .tx_pop, .tx_data_r, .tx_valid_r, .tx_count_r,
    .rx_push, .rx_push_data, .rx_pop, .rx_data_r, .rx_valid_r, .rx_count_r,
    .rx_irq_r, .queue_enable_r
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task results;
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: tests need well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results;
    end
  end

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task tick;
    @(negedge clk);
  endtask

  // Each task ends once the answer has settled
  task wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    tick;
    io_wr = 1'b0;
    tick;
  endtask

  task rd(input logic [7:0] a);
    io_addr = a;
    io_rd = 1'b1;
    tick;
    io_rd = 1'b0;
    tick;
  endtask

  task rpush(input logic [7:0] d);
    rx_push_data = d;
    rx_push = 1'b1;
    tick;
    rx_push = 1'b0;
    tick;
  endtask

  task tpush(input logic [7:0] d);
    tx_push_data = d;
    tx_push = 1'b1;
    tick;
    tx_push = 1'b0;
    tick;
  endtask

  initial begin
    {io_wr, io_rd, tx_push, tx_pop, rx_push, rx_pop} = 6'h00;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    tx_push_data = 8'h00;
    rx_push_data = 8'h00;
    int_code = 3'h2;
    int_none = 1'b0;
    reset = 1'b1;
    repeat (3) tick;
    reset = 1'b0;
    tick;
    chk("queue_enable", 8'h01, {7'h00, queue_enable_r});
    rd(8'hC2);
    chk("ident", 8'hC4, io_rdata_r);
    int_code = 3'h1;
    int_none = 1'b1;
    rd(8'hD2);
    chk("ident other addr", 8'hC4, io_rdata_r);
    rd(8'hC2);
    chk("ident", 8'hC3, io_rdata_r);
    // Every trigger code, threshold crossed one byte at a time
    for (int k = 0; k < 4; k++) begin
      wr(8'hC2, {k[1:0], 6'h05});
      chk("rx_count flushed", 8'h00, {3'h0, rx_count_r});
      for (int n = 1; n <= 16; n++) begin
        rpush(8'(n));
        chk("rx_irq", {7'h00, n >= thr[k]}, {7'h00, rx_irq_r});
      end
    end
    rpush(8'h11);
    chk("rx_count full", 8'h10, {3'h0, rx_count_r});
    chk("rx_irq full", 8'h01, {7'h00, rx_irq_r});
    rx_pop = 1'b1;
    tick;
    chk("rx_data", 8'h01, rx_data_r);
    chk("rx_valid", 8'h01, {7'h00, rx_valid_r});
    tick;
    rx_pop = 1'b0;
    chk("rx_data second", 8'h02, rx_data_r);
    chk("rx_count after pops", 8'h0E, {3'h0, rx_count_r});
    repeat (3) tpush(8'h5A);
    chk("tx_count", 8'h03, {3'h0, tx_count_r});
    wr(8'hC2, 8'h01);
    chk("tx_count no flush", 8'h03, {3'h0, tx_count_r});
    wr(8'hC2, 8'h03);
    chk("tx_count flushed", 8'h00, {3'h0, tx_count_r});
    // Holding-byte mode: threshold and transmit flush ignored
    wr(8'hC2, 8'hC0);
    chk("queue_enable", 8'h00, {7'h00, queue_enable_r});
    rd(8'hC2);
    chk("ident off", 8'h03, io_rdata_r);
    rpush(8'hAA);
    chk("rx_irq off", 8'h01, {7'h00, rx_irq_r});
    rpush(8'hBB);
    chk("rx_count single", 8'h01, {3'h0, rx_count_r});
    tpush(8'h33);
    wr(8'hC2, 8'hC2);
    chk("tx_count off", 8'h01, {3'h0, tx_count_r});
    tx_pop = 1'b1;
    tick;
    tx_pop = 1'b0;
    chk("tx_data hold", 8'h33, tx_data_r);
    chk("tx_valid", 8'h01, {7'h00, tx_valid_r});
    tick;
    chk("tx_valid pulse", 8'h00, {7'h00, tx_valid_r});
    chk("tx_count popped", 8'h00, {3'h0, tx_count_r});
    wr(8'hC2, 8'hC4);
    chk("rx_count off", 8'h00, {3'h0, rx_count_r});
    wr(8'hD2, 8'h01);
    chk("queue_enable other", 8'h00, {7'h00, queue_enable_r});
    results;
  end
endmodule
